// ### fsap_consts.svh
// Purpose: constants of the flash sector access policy block
// Assumes: 16-bit program address space, array ends at the top
// Notes:   sizes, sector bases, frame counts, op/addr fields and keys used by fsap_top live here
`ifndef FSAP_CONSTS_SVH
`define FSAP_CONSTS_SVH

`define FSAP_FLASH_KB        60
`define FSAP_SECTOR_KB       4
`define FSAP_SECT0_BASE      16'hF000
`define FSAP_SECT1_BASE      16'hE000
`define FSAP_FRAME_BITS      6'h20
`define FSAP_READ_BITS       6'h28
`define FSAP_OP_MSB          31
`define FSAP_OP_LSB          24
`define FSAP_ADDR_MSB        23
`define FSAP_ADDR_LSB        8
`define FSAP_UNLOCK_KEY1     8'h56
`define FSAP_UNLOCK_KEY2     8'hAE
`define FSAP_OPT_PROT_BIT    0
`define FSAP_EXTRACT_FILL    8'hFF

`endif

// ### fsap_pkg.sv
// Purpose: types shared by the flash sector access policy block
// Assumes: nothing beyond the constants header
// Notes:   op codes are the low bits of the link frame op byte
package fsap_pkg;

  typedef enum logic [2:0] {
    FSAP_OP_NOP        = 3'b000,
    FSAP_OP_PROG       = 3'b001,
    FSAP_OP_ERASE_SECT = 3'b010,
    FSAP_OP_ERASE_ALL  = 3'b011,
    FSAP_OP_OPT_WR     = 3'b100,
    FSAP_OP_READ       = 3'b101,
    FSAP_OP_UNLOCK     = 3'b110
  } fsap_op_t;

  typedef enum logic [1:0] {
    FSAP_MODE_TOOL = 2'b00,
    FSAP_MODE_ICP  = 2'b01,
    FSAP_MODE_IAP  = 2'b10
  } fsap_mode_t;

  typedef enum logic [1:0] {
    FSAP_ST_IDLE  = 2'b00,
    FSAP_ST_ISSUE = 2'b01,
    FSAP_ST_HOLD  = 2'b10,
    FSAP_ST_WAIT  = 2'b11
  } fsap_state_t;

  typedef enum logic [1:0] {
    FSAP_UL_NONE  = 2'b00,
    FSAP_UL_KEY1  = 2'b01,
    FSAP_UL_ARMED = 2'b10
  } fsap_unlock_t;

  typedef struct packed {
    fsap_op_t    op;
    logic [15:0] addr;
    logic [7:0]  data;
  } fsap_req_t;

  typedef struct packed {
    fsap_op_t    op;
    logic [1:0]  sector;
    logic [15:0] addr;
    logic [7:0]  data;
  } fsap_cmd_t;

endpackage

// ### fsap_props.sv
// Purpose: port assertions for fsap_top
// Assumes: mode inputs steady 5 cycles before judged
// Notes:   bound to every fsap_top
`timescale 1ns/1ps
module fsap_props
  import fsap_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       link_select_program_voltage,
  input wire logic       tool_attached,
  input wire logic       off_board_tool,
  input wire fsap_req_t  cpu_req,
  input wire logic       cpu_req_valid,
  input wire logic       cpu_req_ready,
  input wire fsap_cmd_t  flash_cmd,
  input wire logic       flash_cmd_valid,
  input wire fsap_mode_t prog_mode,
  input wire logic       readout_protected,
  input wire logic       link_pins_for_app,
  input wire logic       req_refused
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [1:0] live_r;
  logic       erased_r;
  // protection loads on the first edges, not a fall
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      live_r   <= 2'h0;
      erased_r <= 1'b0;
    end else begin
      live_r   <= {live_r[0], 1'b1};
      erased_r <= erased_r | (flash_cmd_valid && flash_cmd.op == FSAP_OP_ERASE_ALL);
    end
  end
  property p_iap_s0;
    flash_cmd_valid && prog_mode == FSAP_MODE_IAP |->
      flash_cmd.addr[15:12] != 4'hF && flash_cmd.op != FSAP_OP_ERASE_ALL;
  endproperty
  a_iap_s0: assert property (p_iap_s0) else $error("sector 0 written in app mode");
  property p_sect;
    flash_cmd_valid && flash_cmd.op inside {FSAP_OP_PROG, FSAP_OP_ERASE_SECT} |->
      flash_cmd.addr[15:12] != 4'h0 && flash_cmd.sector == (flash_cmd.addr[15:12] == 4'hF ?
      2'h0 : flash_cmd.addr[15:12] == 4'hE ? 2'h1 : 2'h2);
  endproperty
  a_sect: assert property (p_sect) else $error("wrong sector");
  property p_prot;
    flash_cmd_valid && readout_protected |->
      flash_cmd.op inside {FSAP_OP_ERASE_ALL, FSAP_OP_OPT_WR};
  endproperty
  a_prot: assert property (p_prot) else $error("write while protected");
  property p_pulse;
    flash_cmd_valid |=> !flash_cmd_valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("command valid too long");
  property p_unprot;
    $fell(readout_protected) && live_r[1] |-> erased_r;
  endproperty
  a_unprot: assert property (p_unprot) else $error("unprotect without erase");
  property p_pins_on;
    tool_attached [*5] |-> !link_pins_for_app;
  endproperty
  a_pins_on: assert property (p_pins_on) else $error("link pins given to app");
  property p_pins_off;
    !tool_attached [*5] |-> link_pins_for_app;
  endproperty
  a_pins_off: assert property (p_pins_off) else $error("link pins withheld");
  property p_mode;
    $stable({off_board_tool, link_select_program_voltage}) [*5] |-> prog_mode == (off_board_tool
      ? FSAP_MODE_TOOL : link_select_program_voltage ? FSAP_MODE_ICP : FSAP_MODE_IAP);
  endproperty
  a_mode: assert property (p_mode) else $error("wrong mode");
  property p_answer;
    cpu_req_valid && cpu_req_ready && cpu_req.op != FSAP_OP_UNLOCK |->
      ##[1:8] (flash_cmd_valid || req_refused);
  endproperty
  a_answer: assert property (p_answer) else $error("request unanswered");
endmodule

bind fsap_top fsap_props u_props (.clk(clk), .sys_rst(sys_rst),
  .link_select_program_voltage(link_select_program_voltage), .tool_attached(tool_attached),
  .off_board_tool(off_board_tool), .cpu_req(cpu_req), .cpu_req_valid(cpu_req_valid),
  .cpu_req_ready(cpu_req_ready), .flash_cmd(flash_cmd), .flash_cmd_valid(flash_cmd_valid),
  .prog_mode(prog_mode), .readout_protected(readout_protected),
  .link_pins_for_app(link_pins_for_app), .req_refused(req_refused));

// ### fsap_tb.sv
// Purpose: self-checking bench for fsap_top
// Assumes: flash stays busy 3 cycles per command
// Notes:   link traffic comes from fsap_tool_model
`timescale 1ns/1ps
`include "fsap_consts.svh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module tb
  import fsap_pkg::*;
;
  logic        clk, sys_rst, sel, att, off, prot, rv, busy = 1'b0, seen = 1'b0;
  logic        tool_d, lck, dout, doe_n, rdy, cv, pr, rf;
  logic [15:0] rda, sa[3] = '{16'hF123, 16'hE456, 16'h2000};
  logic [7:0]  b;
  logic [57:0] e, q[$];
  fsap_req_t   req;
  fsap_cmd_t   cmd;
  int          fails, cmp_count, cyc, bc;
  wire         lin = doe_n ? tool_d : dout;
  wire [7:0]   rdd = rda[7:0] ^ 8'h5A;
  fsap_top dut (.clk(clk), .sys_rst(sys_rst), .link_serial_clock(lck),
    .link_serial_data_in(lin), .link_serial_data_out(dout), .link_serial_data_oe_n(doe_n),
    .link_select_program_voltage(sel), .tool_attached(att), .off_board_tool(off),
    .opt_readout_protect(prot), .cpu_req(req), .cpu_req_valid(rv), .cpu_req_ready(rdy),
    .flash_cmd(cmd), .flash_cmd_valid(cv), .flash_busy(busy), .flash_rd_addr(rda),
    .flash_rd_data(rdd), .prog_mode(), .readout_protected(pr), .link_pins_for_app(),
    .req_refused(rf));
  fsap_tool_model tool (.link_serial_clock(lck), .tool_data(tool_d), .line(lin));
  // top 4K is sector 0; refusal expects nothing issued
  function automatic void note(fsap_op_t op, logic [15:0] a, logic [7:0] d, logic ok);
    logic [28:0] m;
    m = !ok || op == FSAP_OP_PROG ? '1 : op == FSAP_OP_ERASE_SECT ? 29'h1F000000 : 29'h1C000000;
    q.push_back({m, 29'(ok ? {op, a[15:12] == 4'hF ? 2'h0 : a[15:12] == 4'hE ? 2'h1 : 2'h2,
      a, d} : 0) & m});
  endfunction
  task automatic go(fsap_op_t op, logic [15:0] a, logic [7:0] d, logic ok, logic lk);
    if (op != FSAP_OP_UNLOCK)
      note(op, a, d, ok);
    if (lk)
      tool.frame({5'h00, op, a, d});
    else begin
      @(posedge clk);
      #1 req = '{op, a, d};
      rv = 1'b1;
      @(negedge clk);
      for (int i = 0; i < 99 && rdy !== 1'b1; i++)
        @(negedge clk);
      @(posedge clk);
      #1 rv = 1'b0;
    end
  endtask
  task automatic w(fsap_op_t op, logic [15:0] a, logic [7:0] d, logic ok, logic lk);
    go(FSAP_OP_UNLOCK, 16'h0000, `FSAP_UNLOCK_KEY1, 1'b1, lk);
    go(FSAP_OP_UNLOCK, 16'h0000, `FSAP_UNLOCK_KEY2, 1'b1, lk);
    go(op, a, d, ok, lk);
  endtask
  task automatic rb(logic [15:0] a, logic [7:0] x);
    tool.rd({5'h00, FSAP_OP_READ, a, 8'h00}, b);
    `CHK("link read", x, b)
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(negedge clk) begin
    seen = cv;
    if (cv === 1'b1 || rf === 1'b1) begin
      e = q.size() > 0 ? q.pop_front() : '1;
      `CHK("flash command", e[28:0], (cv ? cmd : 29'h0) & e[57:29])
    end
  end
  always @(posedge clk) begin
    #1 busy = seen || (busy && bc < 2);
    bc = seen ? 0 : bc + 1;
    if (++cyc == 30000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {sys_rst, prot, rv, sel, att, off} = 6'h30;
    req = '0;
    void'($urandom(32'h58FFD5BC));
    repeat (16) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (8) @(posedge clk);
    #1 {att, sel} = 2'h3;
    repeat (8) @(posedge clk);
    rb(16'hF000, 8'hFF);
    w(FSAP_OP_PROG, 16'hF000, 8'h11, 1'b0, 1'b1);
    note(FSAP_OP_ERASE_ALL, 16'h0000, 8'h00, 1'b1);
    w(FSAP_OP_OPT_WR, 16'h0000, 8'h00, 1'b1, 1'b1);
    repeat (40) @(negedge clk);
    `CHK("protection", 1'b0, pr)
    rb(16'hF0C3, 8'h99);
    $display("test protect done");
    for (int k = 0; k < 2; k++) begin
      foreach (sa[i]) begin
        w(FSAP_OP_PROG, sa[i], 8'($urandom), 1'b1, 1'b1);
        w(FSAP_OP_ERASE_SECT, sa[i], 8'h00, 1'b1, 1'b1);
      end
      w(FSAP_OP_ERASE_ALL, 16'h0000, 8'h00, 1'b1, 1'b1);
      @(posedge clk);
      #1 {off, sel} = 2'h2;
      repeat (8) @(posedge clk);
    end
    $display("test tool modes done");
    #1 {att, off} = 2'h0;
    repeat (8) @(posedge clk);
    repeat (4) w(FSAP_OP_PROG, 16'h1000 + 16'($urandom % 32'hE000), 8'($urandom), 1'b1, 1'b0);
    w(FSAP_OP_ERASE_SECT, 16'hE800, 8'h00, 1'b1, 1'b0);
    w(FSAP_OP_PROG, 16'hFFFE, 8'h34, 1'b0, 1'b0);
    w(FSAP_OP_ERASE_SECT, 16'hF000, 8'h00, 1'b0, 1'b0);
    w(FSAP_OP_ERASE_ALL, 16'h0000, 8'h00, 1'b0, 1'b0);
    w(FSAP_OP_OPT_WR, 16'h0000, 8'h01, 1'b0, 1'b0);
    w(FSAP_OP_PROG, 16'h0FFF, 8'h01, 1'b0, 1'b0);
    go(FSAP_OP_PROG, 16'h2000, 8'h02, 1'b0, 1'b0);
    go(FSAP_OP_UNLOCK, 16'h0000, `FSAP_UNLOCK_KEY1, 1'b1, 1'b0);
    go(FSAP_OP_UNLOCK, 16'h0000, 8'h57, 1'b1, 1'b0);
    go(FSAP_OP_PROG, 16'h2000, 8'h03, 1'b0, 1'b0);
    repeat (50) @(negedge clk);
    `CHK("queue left", 0, q.size())
    $display("test app mode done");
    end_of_test();
  end
endmodule

// ### fsap_tool_model.sv
// Purpose: programming tool on the serial link
// Assumes: link clock period 64 ns for frame bits, 72 ns for answer bits
// Notes:   released data shows the inverse of the last bit
`timescale 1ns/1ps
module fsap_tool_model (
  output logic      link_serial_clock,
  output logic      tool_data,
  input  wire logic line
);
  initial begin
    link_serial_clock = 1'b0;
    tool_data         = 1'b0;
  end
  // msb first, clock low between frames
  task automatic frame(input logic [31:0] f);
    for (int i = 31; i >= 0; i--) begin
      tool_data = f[i];
      #16 link_serial_clock = 1'b1;
      #32 link_serial_clock = 1'b0;
      // idle line shows the inverse, apart from the next frame's first bit
      if (i == 0)
        tool_data = ~tool_data;
      #16;
    end
  endtask
  // device answers on the shared line
  task automatic rd(input logic [31:0] f, output logic [7:0] b);
    frame(f);
    for (int i = 7; i >= 0; i--) begin
      #40 b[i] = line;
      link_serial_clock = 1'b1;
      #32 link_serial_clock = 1'b0;
    end
    #40;
  endtask
endmodule

// ### fsap_top.sv
// Purpose: decides and sequences program/erase of a sectored program flash
// Assumes: flash_busy rises the cycle after flash_cmd_valid; link pins async
// Notes:   link frame = 32 bits msb first, op(8) addr(16) data(8)
`timescale 1ns/1ps
`include "fsap_consts.svh"

module fsap_top
  import fsap_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       link_serial_clock,
  input  wire logic       link_serial_data_in,
  output logic            link_serial_data_out,
  output logic            link_serial_data_oe_n,
  input  wire logic       link_select_program_voltage,
  input  wire logic       tool_attached,
  input  wire logic       off_board_tool,
  input  wire logic       opt_readout_protect,
  input  wire fsap_req_t  cpu_req,
  input  wire logic       cpu_req_valid,
  output logic            cpu_req_ready,
  output fsap_cmd_t       flash_cmd,
  output logic            flash_cmd_valid,
  input  wire logic       flash_busy,
  output logic [15:0]     flash_rd_addr,
  input  wire logic [7:0] flash_rd_data,
  output fsap_mode_t      prog_mode,
  output logic            readout_protected,
  output logic            link_pins_for_app,
  output logic            req_refused
);

  localparam logic [16:0] ARRAY_BYTES = 17'(`FSAP_FLASH_KB * 1024);
  localparam logic [15:0] ARRAY_BASE  = 16'(17'h10000 - ARRAY_BYTES);

  function automatic logic [1:0] sector_count();
    if (`FSAP_FLASH_KB <= `FSAP_SECTOR_KB)
      return 2'h1;
    else if (`FSAP_FLASH_KB <= 2 * `FSAP_SECTOR_KB)
      return 2'h2;
    else
      return 2'h3;
  endfunction

  function automatic logic [1:0] sector_of(input logic [15:0] a);
    if (a >= `FSAP_SECT0_BASE)
      return 2'h0;
    else if (a >= `FSAP_SECT1_BASE)
      return 2'h1;
    else
      return 2'h2;
  endfunction

  function automatic logic in_array(input logic [15:0] a);
    return (a >= ARRAY_BASE) && (sector_of(a) < sector_count());
  endfunction

  // two-flop synchronisers; stage 1 read only by stage 2
  logic [3:0] sync1_r, sync2_r;
  logic       clk_prev_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_r    <= 4'h0;
      sync2_r    <= 4'h0;
      clk_prev_r <= 1'b0;
    end else begin
      sync1_r    <= {tool_attached, link_select_program_voltage,
                     link_serial_data_in, link_serial_clock};
      sync2_r    <= sync1_r;
      clk_prev_r <= sync2_r[0];
    end
  end

  logic lk_rise, lk_fall, lk_data, session, tool_on;
  assign lk_rise = sync2_r[0] & ~clk_prev_r;
  assign lk_fall = ~sync2_r[0] & clk_prev_r;
  assign lk_data = sync2_r[1];
  assign session = sync2_r[2];
  assign tool_on = sync2_r[3];

  assign link_pins_for_app = ~tool_on;

  always_comb begin
    if (off_board_tool)
      prog_mode = FSAP_MODE_TOOL;
    else if (session)
      prog_mode = FSAP_MODE_ICP;
    else
      prog_mode = FSAP_MODE_IAP;
  end

  // link receiver: shift frame, then up to 8 answer bits
  logic        prot_r, prot_nxt;
  logic [31:0] lk_shift_r, lk_shift_nxt;
  logic [5:0]  lk_cnt_r, lk_cnt_nxt;
  logic [7:0]  lk_tx_r, lk_tx_nxt;
  logic        lk_drive_r, lk_drive_nxt;
  logic        lk_frame_done;
  fsap_req_t   lk_req;
  logic        link_ok;

  assign link_ok = session || off_board_tool;
  // one driver for the whole frame view
  assign lk_req = {lk_shift_r[`FSAP_OP_LSB+2:`FSAP_OP_LSB],
                   lk_shift_r[`FSAP_ADDR_MSB:`FSAP_ADDR_LSB], lk_shift_r[7:0]};
  assign flash_rd_addr = lk_req.addr;

  always_comb begin
    lk_shift_nxt  = lk_shift_r;
    lk_cnt_nxt    = lk_cnt_r;
    lk_tx_nxt     = lk_tx_r;
    lk_drive_nxt  = lk_drive_r;
    lk_frame_done = 1'b0;
    if (!link_ok) begin
      lk_cnt_nxt   = 6'h00;
      lk_drive_nxt = 1'b0;
    end else if (lk_rise && lk_cnt_r < `FSAP_FRAME_BITS) begin
      lk_shift_nxt = {lk_shift_r[30:0], lk_data};
      lk_cnt_nxt   = lk_cnt_r + 6'h01;
    end else if (lk_rise && lk_cnt_r < `FSAP_READ_BITS) begin
      lk_cnt_nxt = lk_cnt_r + 6'h01;
      lk_tx_nxt  = {lk_tx_r[6:0], 1'b0};
      if (lk_cnt_r == `FSAP_READ_BITS - 6'h01) begin
        lk_cnt_nxt   = 6'h00;
        lk_drive_nxt = 1'b0;
      end
    end else if (lk_cnt_r == `FSAP_FRAME_BITS && !lk_drive_r) begin
      if (lk_req.op == FSAP_OP_READ) begin
        lk_drive_nxt = 1'b1;
        lk_tx_nxt = prot_r ? `FSAP_EXTRACT_FILL : flash_rd_data;
      end else begin
        lk_frame_done = 1'b1;
        lk_cnt_nxt    = 6'h00;
      end
    end
  end

  assign link_serial_data_out  = lk_tx_r[7];
  assign link_serial_data_oe_n = ~lk_drive_r;

  // policy sequencer
  fsap_state_t  st_r, st_nxt;
  fsap_unlock_t ul_r, ul_nxt;
  fsap_cmd_t    cmd_r, cmd_nxt;
  logic         loaded_r, loaded_nxt;
  logic         unprot_r, unprot_nxt;
  logic         refused_nxt;
  fsap_req_t    req;
  logic         req_v, allow;

  assign cpu_req_ready = (st_r == FSAP_ST_IDLE) && !link_ok && loaded_r;
  assign req   = lk_frame_done ? lk_req : cpu_req;
  assign req_v = lk_frame_done ? (st_r == FSAP_ST_IDLE) : (cpu_req_valid && cpu_req_ready);

  always_comb begin
    allow = 1'b1;
    if (ul_r != FSAP_UL_ARMED)
      allow = 1'b0;
    if (prot_r && req.op != FSAP_OP_OPT_WR)
      allow = 1'b0;
    if (req.op == FSAP_OP_OPT_WR && prog_mode == FSAP_MODE_IAP)
      allow = 1'b0;
    if (prog_mode == FSAP_MODE_IAP && (req.op == FSAP_OP_ERASE_ALL ||
        ((req.op == FSAP_OP_PROG || req.op == FSAP_OP_ERASE_SECT) &&
         sector_of(req.addr) == 2'h0)))
      allow = 1'b0;
    if ((req.op == FSAP_OP_PROG || req.op == FSAP_OP_ERASE_SECT) && !in_array(req.addr))
      allow = 1'b0;
  end

  always_comb begin
    st_nxt      = st_r;
    ul_nxt      = ul_r;
    cmd_nxt     = cmd_r;
    prot_nxt    = prot_r;
    loaded_nxt  = 1'b1;
    unprot_nxt  = unprot_r;
    refused_nxt = 1'b0;
    // option strap caught after reset release
    if (!loaded_r)
      prot_nxt = opt_readout_protect;
    unique case (st_r)
      FSAP_ST_IDLE: begin
        if (req_v && loaded_r) begin
          if (req.op == FSAP_OP_UNLOCK) begin
            if (ul_r == FSAP_UL_NONE && req.data == `FSAP_UNLOCK_KEY1)
              ul_nxt = FSAP_UL_KEY1;
            else if (ul_r == FSAP_UL_KEY1 && req.data == `FSAP_UNLOCK_KEY2)
              ul_nxt = FSAP_UL_ARMED;
            else
              ul_nxt = FSAP_UL_NONE;
          end else if (req.op == FSAP_OP_PROG || req.op == FSAP_OP_ERASE_SECT ||
                       req.op == FSAP_OP_ERASE_ALL || req.op == FSAP_OP_OPT_WR) begin
            ul_nxt = FSAP_UL_NONE;
            if (allow) begin
              cmd_nxt.op     = req.op;
              cmd_nxt.sector = sector_of(req.addr);
              cmd_nxt.addr   = req.addr;
              cmd_nxt.data   = req.data;
              if (req.op == FSAP_OP_OPT_WR && prot_r && !req.data[`FSAP_OPT_PROT_BIT]) begin
                cmd_nxt.op = FSAP_OP_ERASE_ALL;
                unprot_nxt = 1'b1;
              end
              st_nxt = FSAP_ST_ISSUE;
            end else begin
              refused_nxt = 1'b1;
            end
          end
        end
      end
      FSAP_ST_ISSUE: begin
        if (!flash_busy)
          st_nxt = FSAP_ST_HOLD;
      end
      FSAP_ST_HOLD: begin
        st_nxt = FSAP_ST_WAIT;
      end
      FSAP_ST_WAIT: begin
        if (!flash_busy) begin
          st_nxt = FSAP_ST_IDLE;
          if (unprot_r) begin
            unprot_nxt = 1'b0;
            cmd_nxt.op = FSAP_OP_OPT_WR;
            st_nxt     = FSAP_ST_ISSUE;
          end else if (cmd_r.op == FSAP_OP_OPT_WR) begin
            prot_nxt = cmd_r.data[`FSAP_OPT_PROT_BIT];
          end
        end
      end
    endcase
  end

  assign flash_cmd         = cmd_r;
  assign flash_cmd_valid   = (st_r == FSAP_ST_ISSUE) && !flash_busy;
  assign readout_protected = prot_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lk_shift_r  <= 32'h0000_0000;
      lk_cnt_r    <= 6'h00;
      lk_tx_r     <= 8'h00;
      lk_drive_r  <= 1'b0;
      st_r        <= FSAP_ST_IDLE;
      ul_r        <= FSAP_UL_NONE;
      cmd_r       <= '0;
      prot_r      <= 1'b1;
      loaded_r    <= 1'b0;
      unprot_r    <= 1'b0;
      req_refused <= 1'b0;
    end else begin
      lk_shift_r  <= lk_shift_nxt;
      lk_cnt_r    <= lk_cnt_nxt;
      lk_tx_r     <= lk_tx_nxt;
      lk_drive_r  <= lk_drive_nxt;
      st_r        <= st_nxt;
      ul_r        <= ul_nxt;
      cmd_r       <= cmd_nxt;
      prot_r      <= prot_nxt;
      loaded_r    <= loaded_nxt;
      unprot_r    <= unprot_nxt;
      req_refused <= refused_nxt;
    end
  end

endmodule
